// ---- core/jie_consts.svh ----
`ifndef JIE_CONSTS_SVH
`define JIE_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL     8'h00
`define REG_PIDX     8'h04
`define REG_PDATA    8'h08
`define REG_DIDX     8'h0c
`define REG_DDATA    8'h10
`define REG_BANK     8'h14
`define REG_WORK     8'h18
`define REG_FLAGS    8'h1c
`define REG_PC       8'h20
// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_RUN     0
`define FLG_C        0
`define FLG_DC       1
`define FLG_Z        2
`define FLG_OV       3
`define FLG_N        4
`define PH_Q1        0
`define PH_Q4        3
`define PH_RST       4'h1
`define PC_RST       21'h000000
`define PC_STEP      21'h000002
`define IDX_RST      12'h000
`define IDX_STEP     12'h001
`define IR_RST       16'h0000
`define BYTE_RST     8'h00
`define FLAGS_RST    5'h00
`define BANK_RST     4'h0
`define WORD_RST     32'h00000000
// ****************************************
// Instruction encoding
// ****************************************
`define OPC_JUMP     8'hef
`define OPC_INC      6'h0a
`define OPC_INCSZ    6'h0f
`define OPC_INCSNZ   6'h12
`define OPC_MOVE2    4'hc
`define OPC_CALLGRP  6'h3b
`define SECOND_PFX   4'hf
`define DEST_BIT     9
`define ACC_BIT      8
`define ACCESS_SPLIT 8'h80
`define ACC_LO_BANK  4'h0
`define ACC_HI_BANK  4'hf
`define ALU_ONE      8'h01
`define NIB_FULL     4'hf
`define SIGN_MAX     8'h7f
`endif

// ---- core/jie_core_if.sv ----
`timescale 1ns/1ps
interface jie_core_if;
   logic       run;
   logic [3:0] phase;
   logic [7:0] aluIn;
   logic [7:0] aluOut;
   logic [4:0] aluFlags;
   modport seq  (input run, output phase);
   modport alu  (input aluIn, output aluOut, aluFlags);
   modport core (output run, aluIn, input phase, aluOut, aluFlags);
endinterface

// ---- core/jie_exec_core.sv ----
`timescale 1ns/1ps
`include "jie_consts.svh"
// Behaviour
// (RL1) The jump loads its 20-bit literal into PC bits 20..1, so targets are even.
// (RL2) The jump spans all of program space, low 8 bits in word one, upper 12 after 1111.
// (RL3) The jump is two words, two cycles, the second cycle a pure no-operation.
// (RL4) The three increments add one to the file byte; d=0 writes W, d=1 the file.
// (RL5) The assembler default d=1 makes the result go back to the file byte.
// (RL6) a=0 uses the access bank ignoring the bank pointer; a=1 uses the pointer.
// (RL7) The plain increment sets C, DC, N, OV and Z and takes one cycle.
// (RL8) Skip-on-zero discards the prefetched word with an empty cycle when result is 0.
// (RL9) Skip-on-nonzero discards it when the result is not 0, else runs on.
// (RL10) Skipping a two-word instruction costs two empty cycles, three in all.
// (RL11) The 8-bit file address covers a 256-byte bank chosen by the access bit.
// (RL12) Flags follow add-one; the skip variants leave flags alone.
module jie_exec_core
   import jie_pkg::*;
#(
   parameter int PROG_WORDS = 256,
   parameter int NUM_BANKS  = 16
)(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   localparam int PAW = $clog2(PROG_WORDS);
   localparam int DAW = $clog2(NUM_BANKS) + 8;

   jie_core_t   s_q;
   jie_core_t   s_d;
   logic [15:0] progMem [PROG_WORDS];
   logic [7:0]  dataMem [NUM_BANKS*256];
   jie_op_t     op;
   logic [11:0] fAddr;
   logic [15:0] fetchWord;
   logic [20:0] jumpTarget;
   logic        cycEnd;
   logic        skipNow;
   logic        irTwo;
   logic        apbSetup;
   logic        apbWrite;
   logic        badAcc;
   logic        pWe;
   logic        dWe;
   logic [11:0] dWaddr;
   logic [7:0]  dWdata;

   jie_core_if cif ();

   jie_quad_seq u_seq (
      .clk_sys (clk_sys),
      .rst     (rst),
      .cif     (cif)
   );

   jie_inc_alu u_alu (
      .cif (cif)
   );

   // ****************************************
   // Decoding helpers
   // ****************************************
   function automatic jie_op_t decodeOp(input logic [15:0] w);
      if (w[15:8] == `OPC_JUMP) begin
         return OP_JUMP;
      end else if (w[15:10] == `OPC_INC) begin
         return OP_INC;
      end else if (w[15:10] == `OPC_INCSZ || w[15:10] == `OPC_INCSNZ) begin
         return OP_INCSKIP;
      end
      return OP_OTHER;
   endfunction

   function automatic logic isTwoWord(input logic [15:0] w);
      return (w[15:12] == `OPC_MOVE2) || (w[15:10] == `OPC_CALLGRP);
   endfunction

   function automatic logic [11:0] dataAddr(input logic a, input logic [7:0] f,
                                            input logic [3:0] bank);
      // (RL6) access bank or pointer
      if (a) begin
         return {bank, f};
      end else if (f >= `ACCESS_SPLIT) begin
         return {`ACC_HI_BANK, f};
      end
      return {`ACC_LO_BANK, f};
   endfunction

   function automatic logic regKnown(input logic [7:0] a);
      case (a)
         `REG_CTRL, `REG_PIDX, `REG_PDATA, `REG_DIDX, `REG_DDATA,
         `REG_BANK, `REG_WORK, `REG_FLAGS, `REG_PC: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d        = s_q;
      op         = decodeOp(s_q.ir);
      irTwo      = isTwoWord(s_q.ir);
      // (RL11) byte within chosen bank
      fAddr      = dataAddr(s_q.ir[`ACC_BIT], s_q.ir[7:0], s_q.bank);
      cif.run    = s_q.run;
      cif.aluIn  = dataMem[fAddr[DAW-1:0]];
      fetchWord  = progMem[s_q.pc[PAW:1]];
      // (RL2) low byte then prefixed upper bits
      jumpTarget = {fetchWord[11:0], s_q.ir[7:0], 1'b0};
      cycEnd     = s_q.run & cif.phase[`PH_Q4];
      skipNow    = (s_q.ir[15:10] == `OPC_INCSZ) ? (cif.aluOut == `BYTE_RST)
                                                 : (cif.aluOut != `BYTE_RST);
      apbSetup   = psel & ~penable;
      apbWrite   = psel & penable & pwrite;
      // Program and pointer state is frozen while running
      badAcc     = ~regKnown(paddr) | (pwrite & s_q.run & (paddr != `REG_CTRL));
      pWe        = 1'b0;
      dWe        = 1'b0;
      dWaddr     = s_q.dIdx;
      dWdata     = pwdata[7:0];

      // Read data is sampled in the setup phase, held for the access phase
      if (apbSetup) begin
         case (paddr)
            `REG_CTRL:  s_d.rdata = {31'h0, s_q.run};
            `REG_PIDX:  s_d.rdata = {20'h0, s_q.pIdx};
            `REG_PDATA: s_d.rdata = {16'h0, progMem[s_q.pIdx[PAW-1:0]]};
            `REG_DIDX:  s_d.rdata = {20'h0, s_q.dIdx};
            `REG_DDATA: s_d.rdata = {24'h0, dataMem[s_q.dIdx[DAW-1:0]]};
            `REG_BANK:  s_d.rdata = {28'h0, s_q.bank};
            `REG_WORK:  s_d.rdata = {24'h0, s_q.wreg};
            `REG_FLAGS: s_d.rdata = {27'h0, s_q.flags};
            `REG_PC:    s_d.rdata = {11'h0, s_q.pc};
            default:    s_d.rdata = `WORD_RST;
         endcase
      end

      if (apbWrite && !badAcc) begin
         case (paddr)
            `REG_CTRL: begin
               s_d.run = pwdata[`CTRL_RUN];
               if (!s_q.run) begin
                  s_d.state = ST_FLUSH;
               end
            end
            `REG_PIDX: s_d.pIdx = pwdata[11:0];
            `REG_PDATA: begin
               pWe        = 1'b1;
               s_d.pIdx   = s_q.pIdx + `IDX_STEP;
            end
            `REG_DIDX: s_d.dIdx = pwdata[11:0];
            `REG_DDATA: begin
               dWe        = 1'b1;
               s_d.dIdx   = s_q.dIdx + `IDX_STEP;
            end
            `REG_BANK:  s_d.bank  = pwdata[3:0];
            `REG_WORK:  s_d.wreg  = pwdata[7:0];
            `REG_FLAGS: s_d.flags = pwdata[4:0];
            `REG_PC: begin
               s_d.pc    = {pwdata[20:1], 1'b0};
               s_d.state = ST_FLUSH;
            end
            default: ;
         endcase
      end

      // Every instruction cycle ends in Q4 with a prefetch
      if (cycEnd) begin
         s_d.ir    = fetchWord;
         s_d.pc    = s_q.pc + `PC_STEP;
         s_d.state = ST_EXEC;
         case (s_q.state)
            ST_EXEC: begin
               case (op)
                  OP_JUMP: begin
                     // (RL1) literal into PC 20..1
                     s_d.pc    = jumpTarget;
                     // (RL3) second cycle is empty
                     s_d.state = ST_FLUSH;
                  end
                  OP_INC, OP_INCSKIP: begin
                     // (RL4) result to W or file
                     // (RL5) d=1 writes file back
                     if (s_q.ir[`DEST_BIT]) begin
                        dWe    = 1'b1;
                        dWaddr = fAddr;
                        dWdata = cif.aluOut;
                     end else begin
                        s_d.wreg = cif.aluOut;
                     end
                     if (op == OP_INC) begin
                        // (RL7) one cycle, flags updated
                        s_d.flags = cif.aluFlags;
                     end else if (skipNow) begin
                        // (RL8) (RL9) discard prefetched word
                        s_d.state = ST_SKIP;
                     end
                  end
                  default: ;
               endcase
            end
            ST_SKIP: begin
               // (RL10) second word also discarded
               if (irTwo) begin
                  s_d.state = ST_FLUSH;
               end
            end
            ST_FLUSH: ;
            default: s_d.state = ST_FLUSH;
         endcase
      end
   end

   // ****************************************
   // State and memories
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q.state <= ST_FLUSH;
         s_q.run   <= 1'b0;
         s_q.pc    <= `PC_RST;
         s_q.ir    <= `IR_RST;
         s_q.wreg  <= `BYTE_RST;
         s_q.flags <= `FLAGS_RST;
         s_q.bank  <= `BANK_RST;
         s_q.pIdx  <= `IDX_RST;
         s_q.dIdx  <= `IDX_RST;
         s_q.rdata <= `WORD_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // No reset on storage; software loads it before starting the core
   always_ff @(posedge clk_sys) begin
      if (pWe) begin
         progMem[s_q.pIdx[PAW-1:0]] <= pwdata[15:0];
      end
      if (dWe) begin
         dataMem[dWaddr[DAW-1:0]] <= dWdata;
      end
   end

   assign prdata  = s_q.rdata;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & badAcc;

   // ****************************************
   // Checks
   // ****************************************
   a_jump_target: assert property (@(posedge clk_sys) disable iff (rst) // (RL1)
      (cycEnd && s_q.state == ST_EXEC && op == OP_JUMP)
      |=> (s_q.pc == $past(jumpTarget)) && !s_q.pc[0])
      else $error("jump target not loaded");
   a_jump_empty: assert property (@(posedge clk_sys) disable iff (rst) // (RL3)
      (cycEnd && s_q.state == ST_EXEC && op == OP_JUMP)
      |=> (s_q.state == ST_FLUSH)[*4])
      else $error("jump second cycle not empty");
   a_dest_work: assert property (@(posedge clk_sys) disable iff (rst) // (RL4)
      (cycEnd && s_q.state == ST_EXEC && op != OP_JUMP && op != OP_OTHER
       && !s_q.ir[`DEST_BIT]) |=> s_q.wreg == $past(cif.aluOut))
      else $error("W not written");
   a_dest_file: assert property (@(posedge clk_sys) disable iff (rst) // (RL5)
      (cycEnd && s_q.state == ST_EXEC && op != OP_JUMP && op != OP_OTHER
       && s_q.ir[`DEST_BIT]) |-> dWe && dWaddr == fAddr ##1 $stable(s_q.wreg))
      else $error("file write-back missing");
   a_inc_flags: assert property (@(posedge clk_sys) disable iff (rst) // (RL7)
      (cycEnd && s_q.state == ST_EXEC && op == OP_INC)
      |=> s_q.flags == $past(cif.aluFlags) && s_q.state == ST_EXEC)
      else $error("increment flags wrong");
   a_skip_flags: assert property (@(posedge clk_sys) disable iff (rst) // (RL12)
      (cycEnd && s_q.state == ST_EXEC && op == OP_INCSKIP) |=> $stable(s_q.flags))
      else $error("skip variant changed flags");
   a_skip_zero: assert property (@(posedge clk_sys) disable iff (rst) // (RL8)
      (cycEnd && s_q.state == ST_EXEC && s_q.ir[15:10] == `OPC_INCSZ)
      |=> (s_q.state == ST_SKIP) == ($past(cif.aluOut) == `BYTE_RST))
      else $error("skip-on-zero wrong");
   a_skip_nonzero: assert property (@(posedge clk_sys) disable iff (rst) // (RL9)
      (cycEnd && s_q.state == ST_EXEC && s_q.ir[15:10] == `OPC_INCSNZ)
      |=> (s_q.state == ST_SKIP) == ($past(cif.aluOut) != `BYTE_RST))
      else $error("skip-on-nonzero wrong");
   a_skip_double: assert property (@(posedge clk_sys) disable iff (rst) // (RL10)
      (cycEnd && s_q.state == ST_SKIP && irTwo) |=> s_q.state == ST_FLUSH)
      else $error("two-word skip not doubled");
   a_access_bank: assert property (@(posedge clk_sys) disable iff (rst) // (RL6)
      (!s_q.ir[`ACC_BIT] && s_q.bank != `ACC_LO_BANK && !s_q.ir[7])
      |-> fAddr[11:8] == `ACC_LO_BANK)
      else $error("access bank used pointer");
endmodule // jie_exec_core

// ---- core/jie_inc_alu.sv ----
`timescale 1ns/1ps
`include "jie_consts.svh"
module jie_inc_alu
   import jie_pkg::*;
(
   jie_core_if.alu cif
);
   always_comb begin
      cif.aluOut           = cif.aluIn + `ALU_ONE;
      // (RL12) increment flag terms
      cif.aluFlags         = `FLAGS_RST;
      cif.aluFlags[`FLG_C] = &cif.aluIn;
      cif.aluFlags[`FLG_DC] = (cif.aluIn[3:0] == `NIB_FULL);
      cif.aluFlags[`FLG_OV] = (cif.aluIn == `SIGN_MAX);
      cif.aluFlags[`FLG_N] = cif.aluOut[7];
      cif.aluFlags[`FLG_Z] = (cif.aluOut == `BYTE_RST);
   end
endmodule // jie_inc_alu

// ---- core/jie_pkg.sv ----
package jie_pkg;
   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_SKIP  = 3'b010,
      ST_FLUSH = 3'b100
   } jie_state_t;

   typedef enum logic [1:0] {
      OP_OTHER, OP_JUMP, OP_INC, OP_INCSKIP
   } jie_op_t;

   typedef struct packed {
      jie_state_t  state;
      logic        run;
      logic [20:0] pc;
      logic [15:0] ir;
      logic [7:0]  wreg;
      logic [4:0]  flags;
      logic [3:0]  bank;
      logic [11:0] pIdx;
      logic [11:0] dIdx;
      logic [31:0] rdata;
   } jie_core_t;

   typedef struct packed {
      logic [3:0] phase;
   } jie_seq_t;
endpackage

// ---- core/jie_quad_seq.sv ----
`timescale 1ns/1ps
`include "jie_consts.svh"
module jie_quad_seq
   import jie_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   jie_core_if.seq   cif
);
   jie_seq_t s_q;
   jie_seq_t s_d;

   // Stopped core parks in Q1 so a restart opens a clean cycle
   always_comb begin
      s_d = s_q;
      if (cif.run) begin
         s_d.phase = {s_q.phase[2:0], s_q.phase[3]};
      end else begin
         s_d.phase = `PH_RST;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q.phase <= `PH_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign cif.phase = s_q.phase;

   a_phase_onehot: assert property (@(posedge clk_sys) disable iff (rst)
      $onehot(s_q.phase)) else $error("phase not one-hot");
   a_phase_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      (cif.run && s_q.phase[`PH_Q4]) |=> s_q.phase[`PH_Q1])
      else $error("phase did not wrap to Q1");
endmodule // jie_quad_seq

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench
   import jie_pkg::*;
;
   // ****************************************
   // Signals and design
   // ****************************************
   logic        clkSys;
   logic        rst;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        err;
   int          nFail;
   int          nTests;
   int          seed;
   int          prog [0:15];
   int          dm [int];
   int          wm;
   int          fm;
   int          bm;
   int          pcm;

   jie_exec_core #(.PROG_WORDS(256), .NUM_BANKS(16)) u_jie_exec_core (
      .clk_sys (clkSys),
      .rst     (rst),
      .paddr   (paddr),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   always #20 clkSys = ~clkSys;

   // ****************************************
   // Reporting
   // ****************************************
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         nFail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ****************************************
   // Bus master
   // ****************************************
   // Entered just after an edge; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clkSys);
      penable <= 1'b1;
      do begin
         @(posedge clkSys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         nFail++;
         close_out();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clkSys);
      end
   endtask

   // ****************************************
   // Reference model
   // ****************************************
   function automatic int faddr(input int f, input int a);
      return a ? ((bm << 8) | f) : (f < 'h80 ? f : ('hf00 | f));
   endfunction

   task automatic mstep(inout int cyc);
      int w, w2, op, ad, two;
      logic [7:0] r;
      w = prog[(pcm >> 1) & 15];
      op = w >> 10;
      if ((w >> 8) == 'hef) begin
         w2 = prog[((pcm >> 1) + 1) & 15];
         pcm = (((w2 & 'hfff) << 8) | (w & 'hff)) << 1;
         cyc += 2;
      end else if (op == 'h0a || op == 'h0f || op == 'h12) begin
         ad = faddr(w & 'hff, (w >> 8) & 1);
         r = 8'(dm[ad] + 1);
         if (w & 'h200) dm[ad] = r;
         else wm = r;
         if (op == 'h0a) fm = {27'd0, r[7], r == 8'h80, r == 8'h00, r[3:0] == 4'h0, r == 8'h00};
         pcm += 2;
         cyc += 1;
         // skip of one or two words
         if ((op == 'h0f && r == 0) || (op == 'h12 && r != 0)) begin
            w2 = prog[(pcm >> 1) & 15];
            two = ((w2 >> 12) == 'hc) || ((w2 >> 8) >= 'hec && (w2 >> 8) <= 'hef);
            pcm += two ? 4 : 2;
            cyc += two ? 2 : 1;
         end
      end else begin
         pcm += 2;
         cyc += 1;
      end
   endtask

   // ****************************************
   // Program, run and compare
   // ****************************************
   task automatic run_prog(input int nSteps);
      int cyc, j;
      cyc = 0;
      pcm = 0;
      apb(1'b1, 8'h04, 32'h0);
      for (j = 0; j < 10; j++) apb(1'b1, 8'h08, prog[j]);
      apb(1'b1, 8'h14, bm);
      apb(1'b1, 8'h18, wm);
      apb(1'b1, 8'h1c, fm);
      foreach (dm[k]) begin
         apb(1'b1, 8'h0c, k);
         apb(1'b1, 8'h10, dm[k]);
      end
      for (j = 0; j < nSteps; j++) mstep(cyc);
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      // Refused while running; W must stay the model's
      apb(1'b1, 8'h18, 32'h5a);
      check(32'(err), 32'h1);
      // Stop lands on the very edge of the last expected commit
      repeat (4 * cyc - 2) @(posedge clkSys);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      // PC register holds the prefetch address, one word ahead; wraps at 21 bits
      check(rd, (pcm + 2) & 'h1fffff);
      apb(1'b0, 8'h18, 32'h0);
      check(rd, wm);
      apb(1'b0, 8'h1c, 32'h0);
      check(rd, fm);
      foreach (dm[k]) begin
         apb(1'b1, 8'h0c, k);
         apb(1'b0, 8'h10, 32'h0);
         check(rd, dm[k]);
      end
   endtask

   initial begin
      int i, j, f, ops [0:2], vals [0:3], ks [0:3];
      ops = '{'h0a, 'h0f, 'h12};
      seed = 32'h8ed3;
      {clkSys, psel, penable, pwrite, paddr, pwdata} = '0;
      {nFail, nTests} = '0;
      rst = 1'b1;
      repeat (10) @(posedge clkSys);
      rst <= 1'b0;
      @(posedge clkSys);
      apb(1'b1, 8'h20, 32'h13);
      apb(1'b0, 8'h20, 32'h0);
      check(rd, 32'h12);
      apb(1'b0, 8'h24, 32'h0);
      check({rd[30:0], err}, 32'h1);
      // Increments: every op, d, a, edge values, both follower sizes
      for (i = 0; i < 24; i++) begin
         vals = '{'hff, 'h7f, 'h0f, $random(seed) & 'hff};
         for (j = 0; j < 16; j++) prog[j] = 'h2a12;
         f = 'h20 + ($unsigned($random(seed)) % 224);
         prog[0] = (ops[i % 3] << 10) | (((i / 3) % 2) << 9) | (((i / 6) % 2) << 8) | f;
         if (i >= 12) begin
            prog[1] = 'hef08;
            prog[2] = 'hf000;
            prog[3] = 'h2a11;
            prog[8] = 'h2a10;
         end else begin
            prog[1] = 'h2a10;
            prog[2] = 'h2a11;
         end
         bm = $random(seed) & 15;
         wm = $random(seed) & 255;
         fm = $random(seed) & 31;
         dm.delete();
         dm['h10] = 0;
         dm['h11] = 0;
         dm['h12] = 0;
         dm[faddr(f, (i / 6) % 2)] = vals[i % 4];
         run_prog(3);
         $display("increment test %0d done", i);
      end
      // Jumps across the whole space
      ks = '{'hfffff, $random(seed) & 'hfffff, $random(seed) & 'hfffff, 'h00001};
      for (i = 0; i < 4; i++) begin
         for (j = 0; j < 16; j++) prog[j] = 'h2a12;
         prog[0] = 'hef00 | (ks[i] & 'hff);
         prog[1] = 'hf000 | (ks[i] >> 8);
         dm.delete();
         dm['h12] = 0;
         run_prog(1);
         check(32'(pcm), 32'(ks[i] << 1));
         $display("jump test %0d done", i);
      end
      close_out();
   end

   initial begin
      repeat (100000) @(posedge clkSys);
      nFail++;
      close_out();
   end
endmodule // testbench
